// ---- qa_wdt_defines.svh ----
`ifndef QA_WDT_DEFINES_SVH
`define QA_WDT_DEFINES_SVH

// Initial question value and reserved upper nibble
`define QUESTION_INIT 4'hc
`define QUESTION_RSVD 4'h0

// Received answer counter load values per mode
`define ANS_CNT_QA_INIT 2'h3
`define ANS_CNT_WIN_INIT 2'h1
`define ANS_CNT_STEP 2'h1

// Per-cycle answer counts
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1
`define CNT_STEP 3'h1
`define CNT_MAX 3'h7
`define SEQ_MIN_ANSWERS 3'h3
`define QA_CYCLE_ANSWERS 3'h4

// Mode select encoding
`define MODE_QA 1'b0
`define MODE_WIN 1'b1

// Failure counter width
`define FAIL_CNT_W 4

`endif

// ---- qa_wdt_pkg.sv ----
package qa_wdt_pkg;

  typedef logic [2:0] cycle_cnt_t;

  typedef struct packed {
    logic outputDisable;
    logic [1:0] answerCount;
    logic configChange;
    logic wrongAnswer;
    logic tooFewWindow1;
    logic timeOut;
    logic prematureAnswer;
  } status_s;

  typedef struct packed {
    logic strobe;
    logic correct;
    logic inFirstWindow;
  } answer_s;

endpackage

// ---- qa_watchdog_status_question.sv ----
// Operation
// - The current 4-bit question sits in the low nibble of a read-only register, starts at 1100b, and the upper nibble reads zero.
// - Question and status reinitialise on power-on reset, reset-state entry, self-test completion and any watchdog configuration change.
// - An output-disable flag, initially set, is asserted whenever the failure counter reaches or exceeds its threshold.
// - Reading the output-disable flag clears it only while the failure counter is below the threshold.
// - A 2-bit read-only counter advances on every received answer byte.
// - On initialisation the answer counter loads 11b in question-answer mode and 01b in window mode.
// - A clear-on-read flag is set whenever a window duration, the question-answer configuration or the mode bit changes.
// - Answer error, sequence error and time-out are updated at the close of each watchdog cycle, and a status read in between clears them.
// - At cycle end the answer error flag is set if any received answer byte was wrong, else cleared.
// - In question-answer mode the sequence error flag is set when fewer than three answers arrived in the first window.
// - The sequence error flag is only valid when the mode bit is zero.
// - In question-answer mode time-out is set when fewer than four answers arrived in the cycle, cleared at four.
// - In window mode time-out is set when no answer arrived in the cycle, cleared when one arrived.
// - At cycle end the early flag is set for four answers in the first window or one answer in the closed window.
`include "qa_wdt_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module qa_watchdog_status_question
  import qa_wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic resetStateEntry,
  input wire logic selfTestDone,
  input wire logic win1Changed,
  input wire logic win2Changed,
  input wire logic qaCfgChanged,
  input wire logic modeSelect,
  input wire logic questionLoad,
  input wire logic [3:0] questionNext,
  input wire answer_s answerIn,
  input wire logic cycleEnd,
  input wire logic [`FAIL_CNT_W-1:0] failCount,
  input wire logic [`FAIL_CNT_W-1:0] failThreshold,
  input wire logic questionRdStb,
  input wire logic statusRdStb,
  output logic [7:0] questionRdData,
  output status_s statusRdData,
  output logic rdValid
);

  function automatic cycle_cnt_t satInc(cycle_cnt_t c, logic inc);
    satInc = (inc && c != `CNT_MAX) ? cycle_cnt_t'(c + `CNT_STEP) : c;
  endfunction

  logic [3:0] question_reg;
  logic [1:0] answerCount_reg;
  logic outputDisable_reg;
  logic configChange_reg;
  logic wrongAnswer_reg;
  logic tooFewWindow1_reg;
  logic timeOut_reg;
  logic premature_reg;
  logic modePrev_reg;
  cycle_cnt_t win1Cnt_reg;
  cycle_cnt_t totalCnt_reg;
  logic anyWrong_reg;
  logic [7:0] questionRdData_reg;
  status_s statusRdData_reg;
  logic rdValid_reg;

  // Configuration change detection and reinitialisation
  wire logic modeChanged;
  wire logic configEvent;
  wire logic reInit;
  assign modeChanged = modeSelect != modePrev_reg;
  assign configEvent = win1Changed | win2Changed | qaCfgChanged | modeChanged;
  assign reInit = resetStateEntry | selfTestDone | configEvent;

  // Answer accounting, counting the answer of the closing cycle too
  wire logic window1Answer;
  wire cycle_cnt_t win1Now;
  wire cycle_cnt_t totalNow;
  wire logic wrongNow;
  assign window1Answer = answerIn.strobe & answerIn.inFirstWindow;
  assign win1Now = satInc(win1Cnt_reg, window1Answer);
  assign totalNow = satInc(totalCnt_reg, answerIn.strobe);
  assign wrongNow = anyWrong_reg | (answerIn.strobe & ~answerIn.correct);

  // Cycle-end evaluation
  wire logic isQa;
  wire logic wrongEval;
  wire logic tooFewEval;
  wire logic timeOutEval;
  wire logic prematureEval;
  assign isQa = modeSelect == `MODE_QA;
  assign wrongEval = wrongNow;
  assign tooFewEval = isQa && (win1Now < `SEQ_MIN_ANSWERS);
  assign timeOutEval = isQa ? (totalNow < `QA_CYCLE_ANSWERS)
                            : (totalNow == `CNT_ZERO);
  assign prematureEval = isQa ? (win1Now == `QA_CYCLE_ANSWERS)
                              : (win1Now >= `CNT_ONE);

  wire logic failAtThreshold;
  assign failAtThreshold = failCount >= failThreshold;

  wire logic [1:0] answerCountInit;
  assign answerCountInit = (modeSelect == `MODE_WIN) ? `ANS_CNT_WIN_INIT
                                                     : `ANS_CNT_QA_INIT;

  // Next values
  wire logic [3:0] question_next;
  wire logic [1:0] answerCount_next;
  wire logic outputDisable_next;
  wire logic configChange_next;
  wire logic wrongAnswer_next;
  wire logic tooFewWindow1_next;
  wire logic timeOut_next;
  wire logic premature_next;
  wire cycle_cnt_t win1Cnt_next;
  wire cycle_cnt_t totalCnt_next;
  wire logic anyWrong_next;
  wire status_s statusWord;

  assign question_next = reInit ? `QUESTION_INIT
                       : questionLoad ? questionNext : question_reg;
  assign answerCount_next = reInit ? answerCountInit
    : answerIn.strobe ? 2'(answerCount_reg + `ANS_CNT_STEP)
    : answerCount_reg;
  // Threshold keeps the flag set; a read clears it only below threshold
  assign outputDisable_next = reInit | failAtThreshold
    | (outputDisable_reg & ~statusRdStb);
  // Change event wins over a simultaneous read clear
  assign configChange_next = configEvent
    | (configChange_reg & ~statusRdStb & ~resetStateEntry & ~selfTestDone);
  // Error flags move only at cycle end; a read between clears them
  assign wrongAnswer_next = reInit ? 1'b0 : cycleEnd ? wrongEval
    : wrongAnswer_reg & ~statusRdStb;
  assign tooFewWindow1_next = reInit ? 1'b0 : cycleEnd ? tooFewEval
    : tooFewWindow1_reg & ~statusRdStb;
  assign timeOut_next = reInit ? 1'b0 : cycleEnd ? timeOutEval
    : timeOut_reg & ~statusRdStb;
  assign premature_next = reInit ? 1'b0 : cycleEnd ? prematureEval
    : premature_reg & ~statusRdStb;
  assign win1Cnt_next = (reInit | cycleEnd) ? `CNT_ZERO : win1Now;
  assign totalCnt_next = (reInit | cycleEnd) ? `CNT_ZERO : totalNow;
  assign anyWrong_next = ~(reInit | cycleEnd) & wrongNow;

  assign statusWord = '{outputDisable: outputDisable_reg,
                        answerCount: answerCount_reg,
                        configChange: configChange_reg,
                        wrongAnswer: wrongAnswer_reg,
                        tooFewWindow1: tooFewWindow1_reg,
                        timeOut: timeOut_reg,
                        prematureAnswer: premature_reg};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      question_reg <= `QUESTION_INIT;
      answerCount_reg <= `ANS_CNT_QA_INIT;
      outputDisable_reg <= 1'b1;
      configChange_reg <= 1'b0;
      modePrev_reg <= `MODE_QA;
    end else begin
      question_reg <= question_next;
      answerCount_reg <= answerCount_next;
      outputDisable_reg <= outputDisable_next;
      configChange_reg <= configChange_next;
      modePrev_reg <= modeSelect;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrongAnswer_reg <= 1'b0;
      tooFewWindow1_reg <= 1'b0;
      timeOut_reg <= 1'b0;
      premature_reg <= 1'b0;
      win1Cnt_reg <= `CNT_ZERO;
      totalCnt_reg <= `CNT_ZERO;
      anyWrong_reg <= 1'b0;
    end else begin
      wrongAnswer_reg <= wrongAnswer_next;
      tooFewWindow1_reg <= tooFewWindow1_next;
      timeOut_reg <= timeOut_next;
      premature_reg <= premature_next;
      win1Cnt_reg <= win1Cnt_next;
      totalCnt_reg <= totalCnt_next;
      anyWrong_reg <= anyWrong_next;
    end
  end

  // Read data captures the value before any clear takes effect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      questionRdData_reg <= {`QUESTION_RSVD, `QUESTION_INIT};
      statusRdData_reg <= '0;
      rdValid_reg <= 1'b0;
    end else begin
      if (questionRdStb)
        questionRdData_reg <= {`QUESTION_RSVD, question_reg};
      if (statusRdStb)
        statusRdData_reg <= statusWord;
      rdValid_reg <= questionRdStb | statusRdStb;
    end
  end

  assign questionRdData = questionRdData_reg;
  assign statusRdData = statusRdData_reg;
  assign rdValid = rdValid_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  question_read_a: assert property (
    questionRdStb |=> questionRdData == {4'h0, $past(question_reg)})
    else $error("question read data wrong");
  reinit_values_a: assert property (
    reInit |=> question_reg == 4'hc && !wrongAnswer_reg && !timeOut_reg
               && outputDisable_reg)
    else $error("reinitialisation incomplete");
  outdis_set_a: assert property (
    failAtThreshold |=> outputDisable_reg)
    else $error("output disable not set at threshold");
  outdis_clear_a: assert property (
    statusRdStb && !failAtThreshold && !reInit |=> !outputDisable_reg)
    else $error("output disable not cleared by read");
  anscnt_step_a: assert property (
    answerIn.strobe && !reInit |=>
      answerCount_reg == 2'($past(answerCount_reg) + 2'h1))
    else $error("answer counter did not advance");
  anscnt_init_a: assert property (
    reInit |=> answerCount_reg == ($past(modeSelect) ? 2'h1 : 2'h3))
    else $error("answer counter load value wrong");
  cfg_change_a: assert property (
    configEvent |=> configChange_reg ##1 configChange_reg || $past(statusRdStb))
    else $error("configuration change flag lost");
  flag_hold_a: assert property (
    !cycleEnd && !reInit && !statusRdStb |=>
      $stable(wrongAnswer_reg) && $stable(timeOut_reg)
      && $stable(tooFewWindow1_reg))
    else $error("error flags moved mid-cycle");
  wrong_eval_a: assert property (
    cycleEnd && !reInit && answerIn.strobe && !answerIn.correct
      |=> wrongAnswer_reg)
    else $error("wrong answer not flagged");
  seq_eval_a: assert property (
    cycleEnd && !reInit |=>
      tooFewWindow1_reg == (!$past(modeSelect) && $past(win1Now) < 3'h3))
    else $error("sequence error flag wrong");
  seq_mode_a: assert property (
    cycleEnd && !reInit && modeSelect |=> !tooFewWindow1_reg)
    else $error("sequence error set in window mode");
  timeout_qa_a: assert property (
    cycleEnd && !reInit && !modeSelect |=>
      timeOut_reg == ($past(totalNow) < 3'h4))
    else $error("question mode time-out wrong");
  timeout_win_a: assert property (
    cycleEnd && !reInit && modeSelect |=>
      timeOut_reg == ($past(totalNow) == 3'h0))
    else $error("window mode time-out wrong");
  early_eval_a: assert property (
    cycleEnd && !reInit |=> premature_reg == ($past(modeSelect)
      ? ($past(win1Now) != 3'h0) : ($past(win1Now) == 3'h4)))
    else $error("early answer flag wrong");
  read_return_a: assert property (
    statusRdStb |=> statusRdData == $past(statusWord) && rdValid)
    else $error("status read did not return prior value");

  full_qa_cycle_c: cover property (
    answerIn.strobe [*4] ##2 cycleEnd ##1 !timeOut_reg);
  timeout_seen_c: cover property (cycleEnd ##1 timeOut_reg ##1 statusRdStb);
  outdis_read_c: cover property (statusRdStb && failAtThreshold);
  mode_change_c: cover property (modeChanged ##1 configChange_reg);

endmodule // qa_watchdog_status_question

`default_nettype wire

// ---- mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module mcu_model
  import qa_wdt_pkg::*;
(
  input wire logic clk,
  output answer_s answerIn
);
  initial answerIn = '0;

  // Sends n answer bytes, the first f in window 1, the first b wrong
  task automatic send(input int n, input int f, input int b);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      answerIn <= {1'b1, 1'(i >= b), 1'(i < f)};
    end
    @(posedge clk);
    // Idle qualifiers flip so a stale value never looks valid
    answerIn <= {1'b0, ~answerIn.correct, ~answerIn.inFirstWindow};
  endtask
endmodule // mcu_model

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
  import qa_wdt_pkg::*;
  logic clk = 0, rst = 1, modeSelect = 0, questionLoad = 0;
  logic cycleEnd = 0, questionRdStb = 0, statusRdStb = 0;
  logic [4:0] evt = '0;
  logic [3:0] questionNext = '0, failCount = '0, failThreshold = 4'h8;
  logic [3:0] qn;
  answer_s answerIn;
  logic [7:0] questionRdData, got;
  status_s statusRdData;
  logic rdValid, od = 1, cfgc = 0;
  logic [1:0] cnt = 2'h3;
  logic [16:0] q[$], e;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  integer seed = 90;

  always #12.5 clk = ~clk;

  qa_watchdog_status_question dut_u (
    .clk(clk), .rst(rst), .resetStateEntry(evt[0]),
    .selfTestDone(evt[1]), .win1Changed(evt[2]), .win2Changed(evt[3]),
    .qaCfgChanged(evt[4]), .modeSelect(modeSelect),
    .questionLoad(questionLoad), .questionNext(questionNext),
    .answerIn(answerIn), .cycleEnd(cycleEnd), .failCount(failCount),
    .failThreshold(failThreshold), .questionRdStb(questionRdStb),
    .statusRdStb(statusRdStb), .questionRdData(questionRdData),
    .statusRdData(statusRdData), .rdValid(rdValid)
  );

  mcu_model mcu_u (.clk(clk), .answerIn(answerIn));

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end else if (rdValid === 1'b1) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("ERROR rdValid expected 0 seen 1");
      end else begin
        e = q.pop_front();
        got = (e[16] ? statusRdData : questionRdData) & e[15:8];
        samples_checked++;
        if (got !== e[7:0]) begin
          miscompares++;
          $display("ERROR %s expected %h seen %h",
            e[16] ? "statusRdData" : "questionRdData", e[7:0], got);
        end
      end
    end
  end

  task automatic rd(input logic st, input logic [7:0] m, input logic [7:0] v);
    @(posedge clk);
    if (st) statusRdStb <= 1;
    else questionRdStb <= 1;
    q.push_back({st, m, v});
    @(posedge clk);
    statusRdStb <= 0;
    questionRdStb <= 0;
  endtask

  // Status read; flags are {wrong, tooFew, timeOut, early}
  task automatic rs(input logic [7:0] m, input logic [3:0] f);
    rd(1, m, {od, cnt, cfgc, f});
    od = failCount >= failThreshold;
    cfgc = 0;
  endtask

  // With late set, the last answer lands on the cycle-end edge
  task automatic cyc(input int n, input int f, input int b,
                     input bit late = 0);
    logic [3:0] x;
    if (late) begin
      fork
        mcu_u.send(n, f, b);
        begin
          repeat (n) @(posedge clk);
          cycleEnd <= 1;
          @(posedge clk) cycleEnd <= 0;
        end
      join
    end else begin
      mcu_u.send(n, f, b);
      @(posedge clk) cycleEnd <= 1;
      @(posedge clk) cycleEnd <= 0;
    end
    cnt = cnt + 2'(n);
    x = modeSelect ? {b > 0, 1'b0, n == 0, f > 0}
                   : {b > 0, f < 3, n < 4, f == 4};
    // Sequence flag is ignored in window mode
    rs(modeSelect ? 8'hfb : 8'hff, x);
  endtask

  // Events 0..4 pulse a reinit source, 5 flips to window mode
  task automatic ev(input int k);
    @(posedge clk);
    evt <= 5'(1 << k);
    if (k == 5) modeSelect <= 1;
    @(posedge clk) evt <= '0;
    cnt = modeSelect ? 2'h1 : 2'h3;
    od = 1;
    cfgc = k > 1;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(0, 8'hff, 8'h0c);
    rs(8'hff, 4'h0);
    rs(8'hff, 4'h0);
    cyc(4, 2, 0);
    cyc(4, 4, 0);
    cyc(2, 2, 1);
    cyc(3, 3, 0);
    cyc(0, 0, 0);
    cyc(4, 4, 4, 1);
    for (int i = 0; i < 7; i++) begin
      failCount <= 4'($random(seed));
      failThreshold <= 4'($random(seed));
      repeat (2) @(posedge clk);
      od = od | (failCount >= failThreshold);
      rs(8'hff, 4'h0);
    end
    failCount <= '0;
    failThreshold <= 4'h8;
    repeat (2) @(posedge clk);
    rs(8'hff, 4'h0);
    for (int k = 0; k < 6; k++) begin
      qn = 4'($random(seed));
      @(posedge clk);
      questionLoad <= 1;
      questionNext <= qn;
      @(posedge clk) questionLoad <= 0;
      rd(0, 8'hff, {4'h0, qn});
      ev(k);
      rd(0, 8'hff, 8'h0c);
      rs(8'hff, 4'h0);
    end
    // Stay silent until the time-out flag shows after the change
    cyc(0, 0, 0);
    cyc(1, 0, 0);
    cyc(1, 1, 0);
    cyc(1, 0, 1);
    repeat (3) @(posedge clk);
    if (q.size() != 0) begin
      miscompares++;
      $display("ERROR pendingReads expected 0 seen %0d", q.size());
    end
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
